//--- hw/sdinit_host.sv
// SDRAM init sequencer: AXI4-Lite slave for orders, AXI4-Lite master to the controller
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Program timings, geometry, CAS latency, bus width before any command.
// - Mobile parts: write self-refresh, drive strength, partial array settings first.
// - Write the memory type before starting the command sequence.
// - Wait at least 200 us before any SDRAM signal toggles.
// - Mode 1 then one memory write issues a NOP.
// - Mode 2 then one memory write issues precharge all banks.
// - Mode 4 then eight memory writes issue eight auto-refreshes.
// - Mode 3 then a write with both bank bits zero sets mode register.
// - Mobile: mode 5 then a write with a bank bit set sets extended mode.
// - Finish with mode 0 and one write anywhere in memory.
// - Load refresh timer with clock cycles between refreshes.
// - Perform the NOP step exactly as described.
// - Pin controller must hand the pins to the SDRAM controller first; the sequencer writes no pin controller register and starts with the CFG write.
module sdinit_host #(
  parameter logic [31:0] DEV_REG_BASE = sdinit_pkg::DEF_DEV_REG_BASE,
  parameter logic [31:0] SD_BASE = sdinit_pkg::DEF_SD_BASE,
  parameter logic [31:0] LOWPWR_OFS = sdinit_pkg::DEF_LOWPWR_OFS,
  parameter logic [31:0] MEMDEV_OFS = sdinit_pkg::DEF_MEMDEV_OFS,
  parameter int unsigned PAUSE_CYC = sdinit_pkg::PAUSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Software side, AXI4-Lite slave
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Controller side, AXI4-Lite master (write only)
  output logic [31:0] m_awaddr,
  output logic m_awvalid,
  input wire logic m_awready,
  output logic [31:0] m_wdata,
  output logic [3:0] m_wstrb,
  output logic m_wvalid,
  input wire logic m_wready,
  input wire logic [1:0] m_bresp,
  input wire logic m_bvalid,
  output logic m_bready
);

  // ****************************************************************
  // Address mapping
  // ****************************************************************
  function automatic logic [31:0] map_addr(input logic [1:0] bank, input logic [12:0] row,
                                           input logic [10:0] col, input logic [31:0] geom);
    logic [5:0] sh;
    logic [5:0] cb;
    logic [5:0] rb;
    sh = geom[sdinit_pkg::GEOM_BUS16_BIT] ? sdinit_pkg::HALF_SEL_BITS
                                          : sdinit_pkg::WORD_SEL_BITS;
    cb = {2'h0, geom[sdinit_pkg::GEOM_COL_LSB +: 4]};
    rb = {2'h0, geom[sdinit_pkg::GEOM_ROW_LSB +: 4]};
    // Bank bit 1 lands on BA1, bit 0 on BA0
    return SD_BASE | ({21'h0, col} << sh) | ({19'h0, row} << (sh + cb))
           | ({30'h0, bank} << (sh + cb + rb));
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  sdinit_pkg::sdinit_state_t state_ff;
  sdinit_pkg::sdinit_op_t op_kind;
  sdinit_pkg::sdinit_wreq_t op_req;
  logic [4:0] step_ff;
  logic [3:0] rep_ff;
  logic [31:0] pause_cnt_ff;
  logic done_ff, err_ff, start_ff, mobile_ff;
  logic [31:0] cfg_ff, lowpwr_ff, memdev_ff, timer_ff, geom_ff;
  logic s_awready_ff, s_wready_ff, s_bvalid_ff, s_arready_ff, s_rvalid_ff;
  logic [1:0] s_bresp_ff, s_rresp_ff;
  logic [31:0] s_rdata_ff;
  logic m_awvalid_ff, m_wvalid_ff, m_bready_ff;
  sdinit_pkg::sdinit_wreq_t m_req_ff;
  logic wr_fire, rd_fire, b_fire;
  logic [7:0] wofs, rofs;
  logic [31:0] status;

  assign wr_fire = s_awvalid && s_awready_ff && s_wvalid && s_wready_ff;
  assign rd_fire = s_arvalid && s_arready_ff;
  assign b_fire = m_bvalid && m_bready_ff;
  assign wofs = s_awaddr[sdinit_pkg::OFS_W-1:0];
  assign rofs = s_araddr[sdinit_pkg::OFS_W-1:0];

  // ****************************************************************
  // Step decode
  // ****************************************************************
  always_comb begin
    op_kind = sdinit_pkg::OP_WRITE;
    op_req.addr = SD_BASE;
    op_req.data = 32'h0000_0000;
    unique case (step_ff)
      sdinit_pkg::STEP_CFG: begin
        op_req.addr = DEV_REG_BASE + sdinit_pkg::DEV_CFG_OFS;
        op_req.data = cfg_ff;
      end
      sdinit_pkg::STEP_LOWPWR: begin
        op_kind = mobile_ff ? sdinit_pkg::OP_WRITE : sdinit_pkg::OP_SKIP;
        op_req.addr = DEV_REG_BASE + LOWPWR_OFS;
        op_req.data = lowpwr_ff;
      end
      sdinit_pkg::STEP_MEMDEV: begin
        op_req.addr = DEV_REG_BASE + MEMDEV_OFS;
        op_req.data = memdev_ff;
      end
      sdinit_pkg::STEP_PAUSE: op_kind = sdinit_pkg::OP_PAUSE;
      sdinit_pkg::STEP_MODE_NOP: begin
        op_req.addr = DEV_REG_BASE + sdinit_pkg::DEV_MODE_OFS;
        op_req.data = sdinit_pkg::MODE_NOP;
      end
      sdinit_pkg::STEP_MODE_PRE: begin
        op_req.addr = DEV_REG_BASE + sdinit_pkg::DEV_MODE_OFS;
        op_req.data = sdinit_pkg::MODE_PRECHARGE;
      end
      sdinit_pkg::STEP_MODE_REF: begin
        op_req.addr = DEV_REG_BASE + sdinit_pkg::DEV_MODE_OFS;
        op_req.data = sdinit_pkg::MODE_AUTOREF;
      end
      sdinit_pkg::STEP_MODE_MREG: begin
        op_req.addr = DEV_REG_BASE + sdinit_pkg::DEV_MODE_OFS;
        op_req.data = sdinit_pkg::MODE_MREG;
      end
      sdinit_pkg::STEP_SD_MREG: op_req.addr = map_addr(2'h0, 13'h0000, 11'h000, geom_ff);
      sdinit_pkg::STEP_MODE_EXTMREG: begin
        op_kind = mobile_ff ? sdinit_pkg::OP_WRITE : sdinit_pkg::OP_SKIP;
        op_req.addr = DEV_REG_BASE + sdinit_pkg::DEV_MODE_OFS;
        op_req.data = sdinit_pkg::MODE_EXTMREG;
      end
      sdinit_pkg::STEP_SD_EXTMREG: begin
        op_kind = mobile_ff ? sdinit_pkg::OP_WRITE : sdinit_pkg::OP_SKIP;
        op_req.addr = map_addr(2'h1, 13'h0000, 11'h000, geom_ff);
      end
      sdinit_pkg::STEP_MODE_NORM: begin
        op_req.addr = DEV_REG_BASE + sdinit_pkg::DEV_MODE_OFS;
        op_req.data = sdinit_pkg::MODE_NORMAL;
      end
      sdinit_pkg::STEP_TIMER: begin
        op_req.addr = DEV_REG_BASE + sdinit_pkg::DEV_TIMER_OFS;
        op_req.data = timer_ff;
      end
      sdinit_pkg::STEP_SD_NOP, sdinit_pkg::STEP_SD_PRE, sdinit_pkg::STEP_SD_REF,
      sdinit_pkg::STEP_SD_NORM: op_kind = sdinit_pkg::OP_WRITE;
      default: op_kind = sdinit_pkg::OP_END;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= sdinit_pkg::ST_IDLE;
      step_ff <= 5'h00;
      rep_ff <= 4'h0;
      pause_cnt_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        sdinit_pkg::ST_IDLE: begin
          if (start_ff) begin
            step_ff <= sdinit_pkg::STEP_CFG;
            rep_ff <= 4'h0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            state_ff <= sdinit_pkg::ST_ISSUE;
          end
        end
        sdinit_pkg::ST_ISSUE: begin
          unique case (op_kind)
            sdinit_pkg::OP_SKIP: step_ff <= step_ff + sdinit_pkg::STEP_ONE;
            sdinit_pkg::OP_PAUSE: begin
              pause_cnt_ff <= 32'(PAUSE_CYC - 1);
              state_ff <= sdinit_pkg::ST_PAUSE;
            end
            sdinit_pkg::OP_WRITE: state_ff <= sdinit_pkg::ST_RESP;
            sdinit_pkg::OP_END: begin
              done_ff <= 1'b1;
              state_ff <= sdinit_pkg::ST_IDLE;
            end
          endcase
        end
        sdinit_pkg::ST_PAUSE: begin
          if (pause_cnt_ff == 32'h0000_0000) begin
            step_ff <= step_ff + sdinit_pkg::STEP_ONE;
            state_ff <= sdinit_pkg::ST_ISSUE;
          end else begin
            pause_cnt_ff <= pause_cnt_ff - 32'h0000_0001;
          end
        end
        sdinit_pkg::ST_RESP: begin
          // Response marks the command as driven; only then move on
          if (b_fire) begin
            if (m_bresp != sdinit_pkg::RESP_OKAY) begin
              err_ff <= 1'b1;
            end
            if (step_ff == sdinit_pkg::STEP_SD_REF
                && rep_ff != sdinit_pkg::REFRESH_WRITES - 4'h1) begin
              rep_ff <= rep_ff + 4'h1;
            end else begin
              rep_ff <= 4'h0;
              step_ff <= step_ff + sdinit_pkg::STEP_ONE;
            end
            state_ff <= sdinit_pkg::ST_ISSUE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Master write channels
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m_awvalid_ff <= 1'b0;
      m_wvalid_ff <= 1'b0;
      m_bready_ff <= 1'b0;
      m_req_ff <= '0;
    end else if (state_ff == sdinit_pkg::ST_ISSUE && op_kind == sdinit_pkg::OP_WRITE) begin
      m_awvalid_ff <= 1'b1;
      m_wvalid_ff <= 1'b1;
      m_bready_ff <= 1'b1;
      m_req_ff <= op_req;
    end else begin
      if (m_awvalid_ff && m_awready) begin
        m_awvalid_ff <= 1'b0;
      end
      if (m_wvalid_ff && m_wready) begin
        m_wvalid_ff <= 1'b0;
      end
      if (b_fire) begin
        m_bready_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Slave handshakes
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_awready_ff <= 1'b0;
      s_wready_ff <= 1'b0;
      s_bvalid_ff <= 1'b0;
      s_bresp_ff <= sdinit_pkg::RESP_OKAY;
      s_arready_ff <= 1'b0;
      s_rvalid_ff <= 1'b0;
      s_rresp_ff <= sdinit_pkg::RESP_OKAY;
      s_rdata_ff <= 32'h0000_0000;
    end else begin
      s_awready_ff <= !s_bvalid_ff && !s_awready_ff && s_awvalid && s_wvalid;
      s_wready_ff <= !s_bvalid_ff && !s_awready_ff && s_awvalid && s_wvalid;
      if (wr_fire) begin
        s_bvalid_ff <= 1'b1;
        s_bresp_ff <= (wofs <= sdinit_pkg::REG_STATUS && wofs[1:0] == 2'h0)
                      ? sdinit_pkg::RESP_OKAY : sdinit_pkg::RESP_SLVERR;
      end else if (s_bvalid_ff && s_bready) begin
        s_bvalid_ff <= 1'b0;
      end
      s_arready_ff <= !s_rvalid_ff && !s_arready_ff && s_arvalid;
      if (rd_fire) begin
        s_rvalid_ff <= 1'b1;
        s_rresp_ff <= sdinit_pkg::RESP_OKAY;
        unique case (rofs)
          sdinit_pkg::REG_CTRL: s_rdata_ff <= {30'h0, mobile_ff, 1'b0};
          sdinit_pkg::REG_CFG: s_rdata_ff <= cfg_ff;
          sdinit_pkg::REG_LOWPWR: s_rdata_ff <= lowpwr_ff;
          sdinit_pkg::REG_MEMDEV: s_rdata_ff <= memdev_ff;
          sdinit_pkg::REG_TIMER: s_rdata_ff <= timer_ff;
          sdinit_pkg::REG_GEOM: s_rdata_ff <= geom_ff;
          sdinit_pkg::REG_STATUS: s_rdata_ff <= status;
          default: begin
            s_rdata_ff <= 32'h0000_0000;
            s_rresp_ff <= sdinit_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_rvalid_ff && s_rready) begin
        s_rvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[sdinit_pkg::STATUS_BUSY_BIT] = state_ff != sdinit_pkg::ST_IDLE;
    status[sdinit_pkg::STATUS_DONE_BIT] = done_ff;
    status[sdinit_pkg::STATUS_ERR_BIT] = err_ff;
    status[sdinit_pkg::STATUS_STEP_LSB +: 5] = step_ff;
  end

  // ****************************************************************
  // Own registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_ff <= 1'b0;
      mobile_ff <= 1'b0;
      cfg_ff <= 32'h0000_0000;
      lowpwr_ff <= 32'h0000_0000;
      memdev_ff <= 32'h0000_0000;
      timer_ff <= 32'h0000_0000;
      geom_ff <= sdinit_pkg::GEOM_RST;
    end else begin
      start_ff <= 1'b0;
      if (wr_fire) begin
        unique case (wofs)
          sdinit_pkg::REG_CTRL: begin
            // Start ignored while a sequence runs
            start_ff <= s_wstrb[0] && s_wdata[sdinit_pkg::CTRL_START_BIT]
                        && state_ff == sdinit_pkg::ST_IDLE;
            if (s_wstrb[0]) begin
              mobile_ff <= s_wdata[sdinit_pkg::CTRL_MOBILE_BIT];
            end
          end
          sdinit_pkg::REG_CFG: cfg_ff <= apply_strb(cfg_ff, s_wdata, s_wstrb);
          sdinit_pkg::REG_LOWPWR: lowpwr_ff <= apply_strb(lowpwr_ff, s_wdata, s_wstrb);
          sdinit_pkg::REG_MEMDEV: memdev_ff <= apply_strb(memdev_ff, s_wdata, s_wstrb);
          sdinit_pkg::REG_TIMER: timer_ff <= apply_strb(timer_ff, s_wdata, s_wstrb);
          sdinit_pkg::REG_GEOM: geom_ff <= apply_strb(geom_ff, s_wdata, s_wstrb);
          default: start_ff <= 1'b0;
        endcase
      end
    end
  end

  assign s_awready = s_awready_ff;
  assign s_wready = s_wready_ff;
  assign s_bvalid = s_bvalid_ff;
  assign s_bresp = s_bresp_ff;
  assign s_arready = s_arready_ff;
  assign s_rvalid = s_rvalid_ff;
  assign s_rresp = s_rresp_ff;
  assign s_rdata = s_rdata_ff;
  assign m_awaddr = m_req_ff.addr;
  assign m_wdata = m_req_ff.data;
  assign m_wstrb = sdinit_pkg::STRB_ALL;
  assign m_awvalid = m_awvalid_ff;
  assign m_wvalid = m_wvalid_ff;
  assign m_bready = m_bready_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [31:0] pause_seen_ff;
  logic [3:0] ref_cnt_ff;
  logic [31:0] last_mode_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pause_seen_ff <= 32'h0000_0000;
      ref_cnt_ff <= 4'h0;
      last_mode_ff <= 32'h0000_0000;
    end else begin
      pause_seen_ff <= (state_ff == sdinit_pkg::ST_PAUSE) ? pause_seen_ff + 32'h0000_0001
                                                         : 32'h0000_0000;
      if (start_ff) begin
        ref_cnt_ff <= 4'h0;
      end else if (b_fire && step_ff == sdinit_pkg::STEP_SD_REF) begin
        ref_cnt_ff <= ref_cnt_ff + 4'h1;
      end
      if (b_fire && m_req_ff.addr == DEV_REG_BASE + sdinit_pkg::DEV_MODE_OFS) begin
        last_mode_ff <= m_req_ff.data;
      end
    end
  end

  sequence s_sd_issue(logic [4:0] s);
    state_ff == sdinit_pkg::ST_ISSUE && step_ff == s && op_kind == sdinit_pkg::OP_WRITE;
  endsequence

  a_pause_length: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff == sdinit_pkg::ST_PAUSE && pause_cnt_ff == 32'h0000_0000)
    |-> pause_seen_ff == 32'(PAUSE_CYC - 1)) else $error("Pause shorter than required");
  a_nop_mode: assert property (@(posedge clk) disable iff (!rstn)
    s_sd_issue(sdinit_pkg::STEP_SD_NOP) |-> last_mode_ff == sdinit_pkg::MODE_NOP)
    else $error("NOP write without mode 1");
  a_pre_mode: assert property (@(posedge clk) disable iff (!rstn)
    s_sd_issue(sdinit_pkg::STEP_SD_PRE) |-> last_mode_ff == sdinit_pkg::MODE_PRECHARGE)
    else $error("Precharge write without mode 2");
  a_refresh_count: assert property (@(posedge clk) disable iff (!rstn)
    s_sd_issue(sdinit_pkg::STEP_MODE_MREG) |-> ref_cnt_ff == sdinit_pkg::REFRESH_WRITES)
    else $error("Refresh write count wrong");
  a_mreg_bank_zero: assert property (@(posedge clk) disable iff (!rstn)
    s_sd_issue(sdinit_pkg::STEP_SD_MREG) |=> m_awvalid_ff && m_awaddr == SD_BASE
      && last_mode_ff == sdinit_pkg::MODE_MREG) else $error("Mode set address or mode wrong");
  a_extmreg_bank_set: assert property (@(posedge clk) disable iff (!rstn)
    s_sd_issue(sdinit_pkg::STEP_SD_EXTMREG) |=> m_awaddr != SD_BASE
      && last_mode_ff == sdinit_pkg::MODE_EXTMREG) else $error("Extended mode write wrong");
  a_timer_write: assert property (@(posedge clk) disable iff (!rstn)
    s_sd_issue(sdinit_pkg::STEP_TIMER) |=> m_awaddr == DEV_REG_BASE + sdinit_pkg::DEV_TIMER_OFS
      && m_wdata == timer_ff && last_mode_ff == sdinit_pkg::MODE_NORMAL)
    else $error("Refresh timer write wrong");
  a_aw_held: assert property (@(posedge clk) disable iff (!rstn)
    m_awvalid_ff && !m_awready |=> m_awvalid_ff && $stable(m_awaddr))
    else $error("Write address dropped before taken");
  a_bready_held: assert property (@(posedge clk) disable iff (!rstn)
    m_bready_ff && !m_bvalid |=> m_bready_ff && state_ff == sdinit_pkg::ST_RESP)
    else $error("Response wait abandoned");

endmodule

//--- hw/sdinit_pkg.sv
// Constants, types and register layout for the SDRAM init sequencer
package sdinit_pkg;

  // ****************************************************************
  // Bus widths and responses
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int OFS_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_ALL = 4'hf;

  // ****************************************************************
  // Far side: controller register map and memory window
  // ****************************************************************
  localparam logic [31:0] DEV_MODE_OFS = 32'h0000_0000;
  localparam logic [31:0] DEV_TIMER_OFS = 32'h0000_0004;
  localparam logic [31:0] DEV_CFG_OFS = 32'h0000_0008;
  localparam logic [31:0] DEF_LOWPWR_OFS = 32'h0000_001c;
  localparam logic [31:0] DEF_MEMDEV_OFS = 32'h0000_0024;
  localparam logic [31:0] DEF_DEV_REG_BASE = 32'h1000_0000;
  localparam logic [31:0] DEF_SD_BASE = 32'h2000_0000;

  // Command mode field codes
  localparam logic [31:0] MODE_NORMAL = 32'h0000_0000;
  localparam logic [31:0] MODE_NOP = 32'h0000_0001;
  localparam logic [31:0] MODE_PRECHARGE = 32'h0000_0002;
  localparam logic [31:0] MODE_MREG = 32'h0000_0003;
  localparam logic [31:0] MODE_AUTOREF = 32'h0000_0004;
  localparam logic [31:0] MODE_EXTMREG = 32'h0000_0005;

  // Byte select widths below the column field
  localparam logic [5:0] HALF_SEL_BITS = 6'h01;
  localparam logic [5:0] WORD_SEL_BITS = 6'h02;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int PAUSE_NS = 200_000;
  localparam int PAUSE_CYC = (PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] REFRESH_WRITES = 4'h8;

  // ****************************************************************
  // Own registers (byte offsets) and fields
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_LOWPWR = 8'h08;
  localparam logic [7:0] REG_MEMDEV = 8'h0c;
  localparam logic [7:0] REG_TIMER = 8'h10;
  localparam logic [7:0] REG_GEOM = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MOBILE_BIT = 1;
  localparam int GEOM_COL_LSB = 0;
  localparam int GEOM_ROW_LSB = 4;
  localparam int GEOM_BUS16_BIT = 8;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam int STATUS_ERR_BIT = 2;
  localparam int STATUS_STEP_LSB = 8;
  localparam logic [31:0] GEOM_RST = 32'h0000_01c9;

  // ****************************************************************
  // Sequence steps
  // ****************************************************************
  localparam logic [4:0] STEP_CFG = 5'h00;
  localparam logic [4:0] STEP_LOWPWR = 5'h01;
  localparam logic [4:0] STEP_MEMDEV = 5'h02;
  localparam logic [4:0] STEP_PAUSE = 5'h03;
  localparam logic [4:0] STEP_MODE_NOP = 5'h04;
  localparam logic [4:0] STEP_SD_NOP = 5'h05;
  localparam logic [4:0] STEP_MODE_PRE = 5'h06;
  localparam logic [4:0] STEP_SD_PRE = 5'h07;
  localparam logic [4:0] STEP_MODE_REF = 5'h08;
  localparam logic [4:0] STEP_SD_REF = 5'h09;
  localparam logic [4:0] STEP_MODE_MREG = 5'h0a;
  localparam logic [4:0] STEP_SD_MREG = 5'h0b;
  localparam logic [4:0] STEP_MODE_EXTMREG = 5'h0c;
  localparam logic [4:0] STEP_SD_EXTMREG = 5'h0d;
  localparam logic [4:0] STEP_MODE_NORM = 5'h0e;
  localparam logic [4:0] STEP_SD_NORM = 5'h0f;
  localparam logic [4:0] STEP_TIMER = 5'h10;
  localparam logic [4:0] STEP_ONE = 5'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } sdinit_wreq_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ISSUE = 4'h2,
    ST_RESP  = 4'h4,
    ST_PAUSE = 4'h8
  } sdinit_state_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_SKIP  = 2'h1,
    OP_PAUSE = 2'h2,
    OP_END   = 2'h3
  } sdinit_op_t;

endpackage

//--- testbench/sdinit_dev_model.sv
// Stand-in SDRAM controller: write slave logging each write
`timescale 1ns/1ns
module sdinit_dev_model (
  input wire logic clk, rstn, slow,
  input wire logic [31:0] m_awaddr, m_wdata,
  input wire logic m_awvalid, m_wvalid, m_bready,
  output logic m_awready, m_wready, m_bvalid,
  output logic [1:0] m_bresp
);
  logic [31:0] log_a [0:127];
  logic [31:0] log_d [0:127];
  int n;
  logic [1:0] dly_ff;
  // Slow runs refuse the timer write, so the error flag gets exercised
  assign m_bresp = {slow && m_awaddr == sdinit_pkg::DEF_DEV_REG_BASE + 32'h4, 1'b0};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {m_awready, m_wready, m_bvalid, dly_ff, n} <= '0;
    end else begin
      {m_awready, m_wready} <= 2'h0;
      if (m_bvalid && m_bready) m_bvalid <= 1'b0;
      if (m_awready) begin
        log_a[n] <= m_awaddr;
        log_d[n] <= m_wdata;
        n <= n + 1;
        m_bvalid <= 1'b1;
      end else if (m_awvalid && m_wvalid && !m_bvalid) begin
        dly_ff <= dly_ff + 2'h1;
        // Slow mode stalls up to three cycles
        if (!slow || dly_ff == 2'h3) {m_awready, m_wready} <= 2'h3;
      end
    end
  end
endmodule

//--- testbench/tb_sdinit_host.sv
// Self-checking bench for the SDRAM init sequencer
`timescale 1ns/1ns
module tb_sdinit_host;
  localparam logic [31:0] B = sdinit_pkg::DEF_DEV_REG_BASE;
  localparam logic [31:0] S = sdinit_pkg::DEF_SD_BASE;
  logic clk, rstn, slow, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, m_awvalid, m_awready, m_wvalid;
  logic m_wready, m_bvalid, m_bready;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, m_awaddr, m_wdata, ea[$], ed[$];
  logic [3:0] s_wstrb, m_wstrb;
  logic [1:0] s_bresp, s_rresp, m_bresp;
  int n_errors, total_checks, cyc = 0;
  sdinit_host #(.PAUSE_CYC(10)) u_dut (.clk, .rstn, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .m_awaddr, .m_awvalid,
    .m_awready, .m_wdata, .m_wstrb, .m_wvalid, .m_wready, .m_bresp, .m_bvalid, .m_bready);
  sdinit_dev_model u_dev (.clk, .rstn, .slow, .m_awaddr, .m_wdata, .m_awvalid, .m_wvalid,
    .m_bready, .m_awready, .m_wready, .m_bvalid, .m_bresp); // Pins taken as handed over
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_awaddr <= {24'h00_0000, a};
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_awready) {s_awvalid, s_wvalid} <= 2'h0;
      if (s_bvalid) s_bready <= 1'b0;
      if (s_bvalid) chk(s_bresp === r, "bresp");
    end while (!s_bvalid);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_araddr <= {24'h00_0000, a};
    {s_arvalid, s_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b0;
    d = s_rdata;
    r = s_rresp;
  endtask
  task automatic e(input logic [31:0] a, input logic [31:0] d);
    ea.push_back(a);
    ed.push_back(d);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h14, d, r);
    chk(d === sdinit_pkg::GEOM_RST && r === 2'h0, "geom reset");
    rd(8'h1c, d, r);
    chk(r === sdinit_pkg::RESP_SLVERR, "unmapped read");
    wr(8'h1c, 32'h0, sdinit_pkg::RESP_SLVERR);
  endtask
  task automatic t_seq(input logic mob, input logic [31:0] geo, input logic [31:0] ext_adr);
    logic [31:0] d;
    logic [1:0] r;
    int i0;
    int k;
    ea = {};
    ed = {};
    i0 = u_dev.n;
    wr(8'h14, geo, 2'h0);
    wr(8'h04, 32'h0000_1234, 2'h0);
    wr(8'h08, 32'h0000_0005, 2'h0);
    wr(8'h0c, 32'h0000_0001, 2'h0);
    wr(8'h10, 32'h0000_030d, 2'h0);
    wr(8'h00, {30'h0, mob, 1'b1}, 2'h0);
    e(B + 32'h8, 32'h1234);
    if (mob) e(B + 32'h1c, 32'h5);
    e(B + 32'h24, 32'h1);
    e(B, 32'h1);
    e(S, 32'h0);
    e(B, 32'h2);
    e(S, 32'h0);
    e(B, 32'h4);
    repeat (8) e(S, 32'h0);
    e(B, 32'h3);
    e(S, 32'h0);
    if (mob) e(B, 32'h5);
    if (mob) e(ext_adr, 32'h0);
    e(B, 32'h0);
    e(S, 32'h0);
    e(B + 32'h4, 32'h30d);
    k = 0;
    do begin
      rd(8'h18, d, r);
      k++;
    end while (d[1] !== 1'b1 && k < 500);
    chk(d[2:0] === {slow, 2'h2}, "status");
    chk(m_wstrb === sdinit_pkg::STRB_ALL, "strb");
    rd(8'h00, d, r);
    chk(d === {30'h0, mob, 1'b0} && r === 2'h0, "ctrl");
    chk(u_dev.n - i0 == ea.size(), "count");
    foreach (ea[i]) chk(u_dev.log_a[i0+i] === ea[i] && u_dev.log_d[i0+i] === ed[i], "cmd");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) n_errors++;
    if (cyc == 20000) wrap_up();
  end
  initial begin
    {rstn, slow, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_wdata, s_araddr} = '0;
    s_wstrb = sdinit_pkg::STRB_ALL;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_seq(1'b0, sdinit_pkg::GEOM_RST, 32'h0);
    slow <= 1'b1;
    t_seq(1'b1, sdinit_pkg::GEOM_RST, 32'h2040_0000);
    t_seq(1'b1, 32'h0000_00c9, 32'h2080_0000);
    wrap_up();
  end
endmodule
